// ===== include/dtam_pkg.sv
// Constants and types of the dual temperature alarm monitor.
package dtam_pkg;
	localparam logic [7:0] RG_LOCAL = 8'h00;
	localparam logic [7:0] RG_REMOTE = 8'h01;
	localparam logic [7:0] RG_STATUS = 8'h02;
	localparam logic [7:0] RG_CFG_RD = 8'h03;
	localparam logic [7:0] RG_LHL_RD = 8'h05;
	localparam logic [7:0] RG_RHL_RD = 8'h07;
	localparam logic [7:0] RG_CFG_WR = 8'h09;
	localparam logic [7:0] RG_RHL_WR = 8'h0b;
	localparam logic [7:0] RG_LHL_WR = 8'h0d;
	localparam logic [7:0] RG_CRIT_RD = 8'h42;
	localparam logic [7:0] RG_CRIT_WR = 8'h5a;
	localparam logic [7:0] RG_MAKER = 8'hfe;
	localparam logic [7:0] RG_REV = 8'hff;
	// Status bit positions.
	localparam int ST_LCRIT = 0;
	localparam int ST_RCRIT = 1;
	localparam int ST_OPEN = 2;
	localparam int ST_RHIGH = 4;
	localparam int ST_LHIGH = 6;
	// Configuration bit positions.
	localparam int CF_POL = 1;
	localparam int CF_RMASK = 3;
	localparam int CF_LMASK = 4;
	localparam int CF_INTMASK = 7;
	localparam logic [7:0] LIMIT_RST = 8'h7f;
	localparam logic [7:0] ZERO_RST = 8'h00;
	localparam logic [7:0] FAULT_READ = 8'h7f;
	localparam logic [6:0] SLAVE_STRAP00 = 7'h18;
	localparam int MCLK_KHZ = 125000;
	localparam int ROUND_MS = 480;
	localparam int CONV_MS = 60;
	localparam int TMO_MS = 30;
	localparam int SLOT_CYC = ROUND_MS / 2 * MCLK_KHZ;
	localparam int CONV_CYC = CONV_MS * MCLK_KHZ;
	localparam int TMO_CYC = TMO_MS * MCLK_KHZ;
	typedef enum logic [2:0] {
		LS_ADDR = 3'b000,
		LS_PTR = 3'b001,
		LS_DATA = 3'b010,
		LS_SEND = 3'b011,
		LS_IGN = 3'b100
	} dtam_lstate_t;
	typedef struct packed {
		logic is_data;
		logic [7:0] ptr;
		logic [7:0] data;
	} dtam_wr_t;
	typedef struct packed {
		logic [7:0] local_adc;
		logic [7:0] remote_adc;
		logic diode_open;
		logic diode_short;
	} dtam_adc_t;
endpackage

// ===== verilog/dtam_top.sv
// Dual temperature alarm monitor: sequencer, comparators, alarms and bus slave.
// Contract
// - Convert local then remote, repeating; one round lasts about 480 ms.
// - Reading above its high limit sets its high flag and the general alert.
// - Flags set only when a conversion completes, 60 ms after sampling.
// - Status read clears flags; alert falls once read and reading within limit.
// - Configuration bit D7 disables the general alert.
// - Configuration bit D1 picks alert polarity; zero means active low.
// - Any reading above the critical limit raises the critical alarm and its flag.
// - Critical alarm and flags clear after status read and a reading below limit.
// - Per-reading mask blocks its critical flag from the alarm pin only.
// - Pointer and status are zero after power-on.
// - Configuration is zero after power-on; all alarms enabled.
// - Both readings are zero after power-on; each loads at its first conversion, 127 for an open diode.
// - Slave only: clock line is input, data line driven when returning bits.
// - Seven-bit address, bit three fixed at one, rest from two straps.
// - Three-level straps decode to nine addresses, 0x18 through 0x4e.
// - Straps are caught at the first bus transfer, later changes ignored.
// - Readings and limits are 8-bit two's complement, one degree per step.
// - Open diode check before remote conversion forces 127 and sets open flag.
// - In a diode fault the remote critical flag sets if the limit is lower.
// - Diode shorted low reads zero and leaves the open flag clear.
// - Data and both alarm pins drive only low or release.
// - Lines low for the timeout return the serial interface to idle.
// - A start condition restarts the serial interface, expecting an address.
// - Write: address, pointer, data; read uses pointer or sets it first.
`timescale 1ns/1ps
module dtam_top #(
	parameter int SLOT_CYC = dtam_pkg::SLOT_CYC,
	parameter int CONV_CYC = dtam_pkg::CONV_CYC,
	parameter int TMO_CYC = dtam_pkg::TMO_CYC,
	parameter logic [7:0] MAKER_ID = 8'h5a, // Arbitrary value.
	parameter logic [7:0] REV_ID = 8'h3c // Arbitrary value.
) (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_smb_clk,
	input wire logic i_sda_i,
	output logic o_sda_o,
	output logic o_sda_oe,
	input wire logic [1:0] i_addr_strap_a,
	input wire logic [1:0] i_addr_strap_b,
	input wire dtam_pkg::dtam_adc_t i_adc,
	output logic o_adc_sample,
	output logic o_adc_remote,
	output logic o_int_o,
	output logic o_int_oe,
	output logic o_critical_alarm_out_o,
	output logic o_critical_alarm_out_oe
);
	// Address of a strap pair: high three bits one-hot, low three bits a sum.
	function automatic logic [6:0] slave_addr(input logic [1:0] a, input logic [1:0] b);
		logic [2:0] hi, lo_a, lo_b;
		hi = (a == 2'h0) ? 3'h1 : (a == 2'h1) ? 3'h2 : 3'h4;
		lo_a = (a == 2'h0) ? 3'h0 : (a == 2'h1) ? 3'h1 : 3'h4;
		lo_b = (b == 2'h0) ? 3'h0 : (b == 2'h1) ? 3'h1 : 3'h2;
		return {hi, 1'b1, lo_a + lo_b};
	endfunction

	// ===========================================================
	// Pin synchronisers and bus condition detection.
	logic [2:0] scl_s, sda_s;
	logic [1:0] sa_s1, sa_s2, sb_s1, sb_s2;
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			scl_s <= 3'h7;
			sda_s <= 3'h7;
			sa_s1 <= 2'h0;
			sa_s2 <= 2'h0;
			sb_s1 <= 2'h0;
			sb_s2 <= 2'h0;
		end else begin
			scl_s <= {scl_s[1:0], i_smb_clk};
			sda_s <= {sda_s[1:0], i_sda_i};
			sa_s1 <= i_addr_strap_a;
			sa_s2 <= sa_s1;
			sb_s1 <= i_addr_strap_b;
			sb_s2 <= sb_s1;
		end
	end
	wire scl_h = scl_s[1];
	wire start_det = scl_h & scl_s[2] & sda_s[2] & ~sda_s[1];
	wire stop_det = scl_h & scl_s[2] & ~sda_s[2] & sda_s[1];
	logic [31:0] tmo_q, tmo_b_q;
	logic lrst_q, lock_q;
	logic [6:0] addr_q;
	// Each line has its own low-time counter, so busy traffic never looks like a stuck line.
	wire tmo_c_hit = (tmo_q >= 32'(TMO_CYC - 1));
	wire tmo_d_hit = (tmo_b_q >= 32'(TMO_CYC - 1));
	wire tmo_hit = tmo_c_hit | tmo_d_hit;
	wire lrst_d = start_det | stop_det | tmo_hit | (lrst_q & scl_h);
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			tmo_q <= 32'h0;
			tmo_b_q <= 32'h0;
			lrst_q <= 1'b1;
			lock_q <= 1'b0;
			addr_q <= dtam_pkg::SLAVE_STRAP00;
		end else begin
			tmo_q <= scl_h ? 32'h0 : (tmo_c_hit ? tmo_q : tmo_q + 32'h1);
			tmo_b_q <= sda_s[1] ? 32'h0 : (tmo_d_hit ? tmo_b_q : tmo_b_q + 32'h1);
			lrst_q <= lrst_d;
			if (start_det & ~lock_q) begin
				lock_q <= 1'b1;
				addr_q <= slave_addr(sa_s2, sb_s2);
			end
		end
	end

	// ===========================================================
	// Link side, clocked by the host's bus clock.
	dtam_pkg::dtam_lstate_t ls_q;
	logic [3:0] bit_q;
	logic [7:0] sh_q, ptr_l_q;
	logic ack_q, mack_q, wr_tgl_q, rd_tgl_q;
	dtam_pkg::dtam_wr_t wr_l_q;
	logic [7:0] rd_byte_q;
	wire [7:0] rx_byte = {sh_q[6:0], i_sda_i};
	wire last_bit = (bit_q == 4'h7);
	wire addr_hit = (rx_byte[7:1] == addr_q);
	always_ff @(posedge i_smb_clk or posedge lrst_q) begin
		if (lrst_q) begin
			ls_q <= dtam_pkg::LS_ADDR;
			bit_q <= 4'h0;
			sh_q <= 8'h0;
			ack_q <= 1'b0;
			mack_q <= 1'b0;
			ptr_l_q <= 8'h0;
		end else begin
			bit_q <= (bit_q == 4'h8) ? 4'h0 : bit_q + 4'h1;
			sh_q <= rx_byte;
			if (bit_q == 4'h8)
				mack_q <= ~i_sda_i;
			if (last_bit) begin
				ack_q <= 1'b0;
				case (ls_q)
				dtam_pkg::LS_ADDR: begin
					ack_q <= addr_hit;
					ls_q <= !addr_hit ? dtam_pkg::LS_IGN :
						(rx_byte[0] ? dtam_pkg::LS_SEND : dtam_pkg::LS_PTR);
				end
				dtam_pkg::LS_PTR: begin
					ack_q <= 1'b1;
					ptr_l_q <= rx_byte;
					ls_q <= dtam_pkg::LS_DATA;
				end
				dtam_pkg::LS_DATA: begin
					ack_q <= 1'b1;
					ls_q <= dtam_pkg::LS_IGN;
				end
				default: ls_q <= ls_q;
				endcase
			end else if (bit_q == 4'h8 && ls_q == dtam_pkg::LS_SEND && i_sda_i) begin
				ls_q <= dtam_pkg::LS_IGN;
			end
		end
	end
	// Event toggles survive bus restarts so the far side never sees a false edge.
	wire rd_ask = (last_bit & ls_q == dtam_pkg::LS_ADDR & addr_hit & rx_byte[0]) |
		(bit_q == 4'h8 & ls_q == dtam_pkg::LS_SEND & ~ack_q & ~i_sda_i);
	wire wr_ask = last_bit & (ls_q == dtam_pkg::LS_PTR | ls_q == dtam_pkg::LS_DATA);
	always_ff @(posedge i_smb_clk or posedge i_rst) begin
		if (i_rst) begin
			wr_tgl_q <= 1'b0;
			rd_tgl_q <= 1'b0;
			wr_l_q <= '0;
		end else begin
			rd_tgl_q <= rd_tgl_q ^ rd_ask;
			if (wr_ask) begin
				wr_tgl_q <= ~wr_tgl_q;
				wr_l_q.is_data <= (ls_q == dtam_pkg::LS_DATA);
				wr_l_q.ptr <= (ls_q == dtam_pkg::LS_DATA) ? ptr_l_q : rx_byte;
				wr_l_q.data <= rx_byte;
			end
		end
	end
	// Data changes only while the clock is low; ack and read bits pull low.
	wire send_bit = (ls_q == dtam_pkg::LS_SEND) & (bit_q < 4'h8) &
		(bit_q != 4'h0 | mack_q | ack_q);
	always_ff @(negedge i_smb_clk or posedge lrst_q) begin
		if (lrst_q) begin
			o_sda_oe <= 1'b0;
		end else begin
			o_sda_oe <= ((bit_q == 4'h8) & ack_q) |
				(send_bit & ~rd_byte_q[3'(4'h7 - bit_q)]);
		end
	end
	assign o_sda_o = 1'b0;

	// ===========================================================
	// Crossing of write and read events into the system clock.
	logic [2:0] wr_s, rd_s;
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			wr_s <= 3'h0;
			rd_s <= 3'h0;
		end else begin
			wr_s <= {wr_s[1:0], wr_tgl_q};
			rd_s <= {rd_s[1:0], rd_tgl_q};
		end
	end
	wire wr_ev = wr_s[2] ^ wr_s[1];
	wire rd_ev = rd_s[2] ^ rd_s[1];

	// ===========================================================
	// Register file.
	logic [7:0] ptr_q, cfg_q, lhl_q, rhl_q, crit_q, local_q, remote_q, status_q;
	logic [1:0] hi_now_q, cr_now_q;
	logic open_now_q;
	wire wd = wr_ev & wr_l_q.is_data;
	wire st_rd = rd_ev & (ptr_q == dtam_pkg::RG_STATUS);
	wire [7:0] rd_mux =
		(ptr_q == dtam_pkg::RG_LOCAL) ? local_q :
		(ptr_q == dtam_pkg::RG_REMOTE) ? remote_q :
		(ptr_q == dtam_pkg::RG_STATUS) ? status_q :
		(ptr_q == dtam_pkg::RG_CFG_RD) ? cfg_q :
		(ptr_q == dtam_pkg::RG_LHL_RD) ? lhl_q :
		(ptr_q == dtam_pkg::RG_RHL_RD) ? rhl_q :
		(ptr_q == dtam_pkg::RG_CRIT_RD) ? crit_q :
		(ptr_q == dtam_pkg::RG_MAKER) ? MAKER_ID :
		(ptr_q == dtam_pkg::RG_REV) ? REV_ID : 8'h00;

	// ===========================================================
	// Conversion sequencer and comparators.
	logic [31:0] slot_q;
	logic chan_q;
	wire slot_end = (slot_q == 32'(SLOT_CYC - 1));
	wire conv_done = (slot_q == 32'(CONV_CYC - 1));
	wire [7:0] new_read = !chan_q ? i_adc.local_adc :
		i_adc.diode_open ? dtam_pkg::FAULT_READ :
		i_adc.diode_short ? dtam_pkg::ZERO_RST : i_adc.remote_adc;
	wire new_hi = $signed(new_read) > $signed(chan_q ? rhl_q : lhl_q);
	wire new_cr = $signed(new_read) > $signed(crit_q);
	logic [7:0] set_v, keep_v, st_d;
	always_comb begin
		set_v = 8'h0;
		keep_v = 8'h0;
		if (conv_done) begin
			set_v[chan_q ? dtam_pkg::ST_RHIGH : dtam_pkg::ST_LHIGH] = new_hi;
			set_v[chan_q ? dtam_pkg::ST_RCRIT : dtam_pkg::ST_LCRIT] = new_cr;
			set_v[dtam_pkg::ST_OPEN] = chan_q & i_adc.diode_open;
		end
		keep_v[dtam_pkg::ST_LHIGH] = hi_now_q[0];
		keep_v[dtam_pkg::ST_RHIGH] = hi_now_q[1];
		keep_v[dtam_pkg::ST_LCRIT] = cr_now_q[0];
		keep_v[dtam_pkg::ST_RCRIT] = cr_now_q[1];
		keep_v[dtam_pkg::ST_OPEN] = open_now_q;
		// A set in the same cycle as the clearing read wins.
		st_d = (st_rd ? (status_q & keep_v) : status_q) | set_v;
	end
	wire int_act = ~cfg_q[dtam_pkg::CF_INTMASK] &
		(status_q[dtam_pkg::ST_LHIGH] | status_q[dtam_pkg::ST_RHIGH]);
	wire crit_act = (status_q[dtam_pkg::ST_LCRIT] & ~cfg_q[dtam_pkg::CF_LMASK]) |
		(status_q[dtam_pkg::ST_RCRIT] & ~cfg_q[dtam_pkg::CF_RMASK]);

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			slot_q <= 32'h0;
			chan_q <= 1'b0;
			ptr_q <= dtam_pkg::ZERO_RST;
			status_q <= dtam_pkg::ZERO_RST;
			cfg_q <= dtam_pkg::ZERO_RST;
			local_q <= dtam_pkg::ZERO_RST;
			remote_q <= dtam_pkg::ZERO_RST;
			lhl_q <= dtam_pkg::LIMIT_RST;
			rhl_q <= dtam_pkg::LIMIT_RST;
			crit_q <= dtam_pkg::LIMIT_RST;
			hi_now_q <= 2'h0;
			cr_now_q <= 2'h0;
			open_now_q <= 1'b0;
			rd_byte_q <= 8'h0;
			o_adc_sample <= 1'b0;
			o_adc_remote <= 1'b0;
			o_int_oe <= 1'b0;
			o_critical_alarm_out_oe <= 1'b0;
		end else begin
			slot_q <= slot_end ? 32'h0 : slot_q + 32'h1;
			chan_q <= chan_q ^ slot_end;
			o_adc_sample <= (slot_q == 32'h0);
			o_adc_remote <= chan_q;
			if (conv_done) begin
				if (chan_q) begin
					remote_q <= new_read;
					hi_now_q[1] <= new_hi;
					cr_now_q[1] <= new_cr;
					open_now_q <= i_adc.diode_open;
				end else begin
					local_q <= new_read;
					hi_now_q[0] <= new_hi;
					cr_now_q[0] <= new_cr;
				end
			end
			status_q <= st_d;
			if (rd_ev)
				rd_byte_q <= rd_mux;
			if (wr_ev)
				ptr_q <= wr_l_q.ptr;
			if (wd && wr_l_q.ptr == dtam_pkg::RG_CFG_WR)
				cfg_q <= wr_l_q.data;
			if (wd && wr_l_q.ptr == dtam_pkg::RG_LHL_WR)
				lhl_q <= wr_l_q.data;
			if (wd && wr_l_q.ptr == dtam_pkg::RG_RHL_WR)
				rhl_q <= wr_l_q.data;
			if (wd && wr_l_q.ptr == dtam_pkg::RG_CRIT_WR)
				crit_q <= wr_l_q.data;
			o_int_oe <= int_act ^ cfg_q[dtam_pkg::CF_POL];
			o_critical_alarm_out_oe <= crit_act;
		end
	end
	assign o_int_o = 1'b0;
	assign o_critical_alarm_out_o = 1'b0;

	// ===========================================================
	// Checks.
	property p_round;
		@(posedge i_mclk) disable iff (i_rst) slot_end |=> chan_q != $past(chan_q);
	endproperty
	a_round: assert property (p_round) else $error("channel did not alternate");
	property p_lhigh;
		@(posedge i_mclk) disable iff (i_rst)
		conv_done && !chan_q && new_hi |=> status_q[dtam_pkg::ST_LHIGH] ##1
			($past(cfg_q[dtam_pkg::CF_INTMASK]) || o_int_oe != $past(cfg_q[dtam_pkg::CF_POL]));
	endproperty
	a_lhigh: assert property (p_lhigh) else $error("local high not flagged");
	property p_quiet;
		@(posedge i_mclk) disable iff (i_rst) !conv_done && !st_rd |=> $stable(status_q);
	endproperty
	a_quiet: assert property (p_quiet) else $error("status moved without cause");
	property p_mask;
		@(posedge i_mclk) disable iff (i_rst)
		cfg_q[dtam_pkg::CF_INTMASK] |=> o_int_oe == $past(cfg_q[dtam_pkg::CF_POL]);
	endproperty
	a_mask: assert property (p_mask) else $error("masked alert asserted");
	property p_crit;
		@(posedge i_mclk) disable iff (i_rst) ##1 o_critical_alarm_out_oe == $past(crit_act);
	endproperty
	a_crit: assert property (p_crit) else $error("critical pin wrong");
	property p_hold;
		@(posedge i_mclk) disable iff (i_rst)
		status_q[dtam_pkg::ST_RCRIT] && !(st_rd && !cr_now_q[1]) |=> status_q[dtam_pkg::ST_RCRIT];
	endproperty
	a_hold: assert property (p_hold) else $error("critical flag lost");
	property p_open;
		@(posedge i_mclk) disable iff (i_rst)
		conv_done && chan_q && i_adc.diode_open |=> remote_q == dtam_pkg::FAULT_READ
			&& status_q[dtam_pkg::ST_OPEN];
	endproperty
	a_open: assert property (p_open) else $error("open diode not reported");
	property p_lock;
		@(posedge i_mclk) disable iff (i_rst) lock_q |=> $stable(addr_q) && addr_q[3];
	endproperty
	a_lock: assert property (p_lock) else $error("slave address moved");
	property p_restart;
		@(posedge i_mclk) disable iff (i_rst) start_det || tmo_hit |=> lrst_q;
	endproperty
	a_restart: assert property (p_restart) else $error("interface not reset");
endmodule

// ===== tb/dtam_host.sv
// SMBus host model that drives the clock and data lines of the monitor.
`timescale 1ns/1ps
module dtam_host #(
	parameter int HALF = 4
) (
	input wire logic i_lclk,
	input wire logic i_sda,
	output logic o_scl,
	output logic o_sda_pull
);
	initial begin
		o_scl = 1'b1;
		o_sda_pull = 1'b0;
	end
	task automatic tk(input int n);
		repeat (n) @(posedge i_lclk);
	endtask
	// ==========================================================
	// Line conditions
	// The clock is made here alone and stands high between frames, except after part, which leaves it low.
	task automatic start();
		o_sda_pull <= 1'b0;
		tk(HALF);
		o_scl <= 1'b1;
		tk(HALF);
		o_sda_pull <= 1'b1;
		tk(HALF);
		o_scl <= 1'b0;
		tk(1);
	endtask
	task automatic stop();
		o_sda_pull <= 1'b1;
		tk(HALF);
		o_scl <= 1'b1;
		tk(HALF);
		o_sda_pull <= 1'b0;
		tk(HALF);
	endtask
	// Data changes one tick after the clock falls, so it never races a start or stop.
	task automatic xfer(input logic [8:0] tx, input int nb, output logic [8:0] rx);
		rx = '1;
		for (int i = 8; i > 8 - nb; i--) begin
			o_sda_pull <= ~tx[i];
			tk(HALF);
			o_scl <= 1'b1;
			tk(HALF);
			rx[i] = i_sda;
			o_scl <= 1'b0;
			tk(1);
		end
	endtask
	// ==========================================================
	// Transfers
	// A write carries address, pointer and one data byte.
	task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d,
		output logic ok);
		logic [8:0] r0, r1, r2;
		start();
		xfer({a, 1'b0, 1'b1}, 9, r0);
		xfer({p, 1'b1}, 9, r1);
		xfer({d, 1'b1}, 9, r2);
		stop();
		ok = ~(r0[0] | r1[0] | r2[0]);
	endtask
	// A read sets the pointer and repeats the start, or uses the latched pointer.
	task automatic rd(input logic [6:0] a, input logic [7:0] p, input logic use_ptr,
		output logic [7:0] d, output logic ok);
		logic [8:0] r0, r1, r2, r3;
		r0 = '0;
		r1 = '0;
		start();
		if (use_ptr) begin
			xfer({a, 1'b0, 1'b1}, 9, r0);
			xfer({p, 1'b1}, 9, r1);
			start();
		end
		xfer({a, 1'b1, 1'b1}, 9, r2);
		xfer(9'h1ff, 9, r3);
		stop();
		d = r3[8:1];
		ok = ~(r0[0] | r1[0] | r2[0]);
	endtask
	// Starts a frame and sends only nb bits, then leaves the clock low.
	task automatic part(input logic [8:0] tx, input int nb);
		logic [8:0] r;
		start();
		xfer(tx, nb, r);
	endtask
endmodule

// ===== tb/testbench.sv
// Self-checking bench for the dual temperature alarm monitor.
`timescale 1ns/1ps
module testbench;
	localparam int SLOT = 200;
	localparam int CONV = 50;
	localparam int TMO = 400;
	logic mclk = 1'b0;
	logic lclk = 1'b0;
	logic rst = 1'b1;
	logic scl, pull, sda_o, sda_oe, smp, rem, int_o, int_oe, crit_o, crit_oe, ok;
	logic [1:0] sa = 2'd0;
	logic [1:0] sb = 2'd0;
	logic [6:0] addr;
	logic [7:0] d, lr, rr, lh, rh, cr, cf, re, st, r0;
	logic [15:0] fx;
	dtam_pkg::dtam_adc_t adc = '0;
	wire sda = ~(pull | (sda_oe & ~sda_o));
	int n_mismatch = 0;
	int checks_done = 0;
	int seed = 32'hdc99;
	int n;
	always #4 mclk = ~mclk;
	initial begin
		#2.7;
		forever #6 lclk = ~lclk;
	end
	dtam_top #(.SLOT_CYC(SLOT), .CONV_CYC(CONV), .TMO_CYC(TMO)) dut_u (
		.i_mclk(mclk),
		.i_rst(rst),
		.i_smb_clk(scl),
		.i_sda_i(sda),
		.o_sda_o(sda_o),
		.o_sda_oe(sda_oe),
		.i_addr_strap_a(sa),
		.i_addr_strap_b(sb),
		.i_adc(adc),
		.o_adc_sample(smp),
		.o_adc_remote(rem),
		.o_int_o(int_o),
		.o_int_oe(int_oe),
		.o_critical_alarm_out_o(crit_o),
		.o_critical_alarm_out_oe(crit_oe)
	);
	dtam_host host_u (
		.i_lclk(lclk),
		.i_sda(sda),
		.o_scl(scl),
		.o_sda_pull(pull)
	);
	// ==========================================================
	// Checking and helpers
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %0t byte got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %0t bit got %b exp %b", $time, got, exp);
		end
	endtask
	task automatic summarize();
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge mclk);
		#1;
	endtask
	task automatic do_reset();
		rst = 1'b1;
		cyc(6);
		rst = 1'b0;
		cyc(5);
	endtask
	task automatic rdc(input logic [7:0] p, input logic [7:0] exp);
		host_u.rd(addr, p, 1'b1, d, ok);
		chk1(ok, 1'b1);
		chk8(d, exp);
	endtask
	task automatic wrc(input logic [7:0] p, input logic [7:0] v);
		host_u.wr(addr, p, v, ok);
		chk1(ok, 1'b1);
	endtask
	task automatic wait_smp(output int k);
		k = 0;
		do begin
			cyc(1);
			k++;
		end while (smp !== 1'b1 && k < 3 * SLOT);
	endtask
	function automatic logic [6:0] exp_addr(input logic [1:0] a, input logic [1:0] b);
		logic [2:0] hi;
		hi = 3'b001 << a;
		return {hi, 1'b1, ((a == 2'd2) ? 3'd4 : {1'b0, a}) + {1'b0, b}};
	endfunction
	function automatic logic [7:0] exp_st(input logic [7:0] l, input logic [7:0] r,
		input logic op);
		logic [7:0] s;
		s = 8'h00;
		s[dtam_pkg::ST_LCRIT] = $signed(l) > $signed(cr);
		s[dtam_pkg::ST_RCRIT] = $signed(r) > $signed(cr);
		s[dtam_pkg::ST_OPEN] = op;
		s[dtam_pkg::ST_RHIGH] = $signed(r) > $signed(rh);
		s[dtam_pkg::ST_LHIGH] = $signed(l) > $signed(lh);
		return s;
	endfunction
	initial begin
		#600000;
		n_mismatch++;
		summarize();
	end
	// ==========================================================
	// Main sequence
	initial begin
		for (int a = 0; a < 3; a++) begin
			for (int b = 0; b < 3; b++) begin
				sa = a[1:0];
				sb = b[1:0];
				do_reset();
				addr = exp_addr(sa, sb);
				host_u.rd(addr, 8'h00, 1'b0, d, ok);
				chk8({ok, d[6:0]}, 8'h80);
				rdc(dtam_pkg::RG_STATUS, 8'h00);
			end
		end
		chk8({int_o, crit_o, sda_o, int_oe, crit_oe, 3'b0}, 8'h00);
		rdc(dtam_pkg::RG_CFG_RD, 8'h00);
		rdc(dtam_pkg::RG_CRIT_RD, dtam_pkg::LIMIT_RST);
		sa = 2'd0;
		sb = 2'd0;
		cyc(4);
		rdc(dtam_pkg::RG_LHL_RD, dtam_pkg::LIMIT_RST);
		host_u.rd(7'h18, dtam_pkg::RG_CFG_RD, 1'b1, d, ok);
		chk1(ok, 1'b0);
		host_u.part({addr, 1'b0, 1'b1}, 8);
		cyc(2);
		chk1(sda_oe, 1'b1);
		cyc(TMO + 20);
		chk1(sda_oe, 1'b0);
		host_u.stop();
		host_u.part(9'h0a5, 3);
		rdc(dtam_pkg::RG_RHL_RD, dtam_pkg::LIMIT_RST);
		wait_smp(n);
		cyc(2);
		for (int j = 0; j < 2; j++) begin
			r0 = {7'd0, rem};
			wait_smp(n);
			chk8(8'(n), 8'(SLOT - 2));
			cyc(2);
			chk1(rem, ~r0[0]);
		end
		for (int k = 0; k < 6; k++) begin
			{lr, rr, lh, rh} = $random(seed);
			{cr, cf, fx} = $random(seed);
			if (k == 0) begin
				{lh, rr, rh, cr, cf, fx} = {lr, 8'h05, 8'he7, 8'h00, 8'h28, 16'h2};
			end
			if (k == 1) begin
				{cr, fx} = {8'h7e, 16'h0};
			end
			if (k == 2) begin
				fx = 16'h1;
			end
			re = (fx[1:0] == 2'd0) ? 8'h7f : (fx[1:0] == 2'd1) ? 8'h00 : rr;
			adc = '{lr, rr, fx[1:0] == 2'd0, fx[1:0] == 2'd1};
			wrc(dtam_pkg::RG_LHL_WR, lh);
			wrc(dtam_pkg::RG_RHL_WR, rh);
			wrc(dtam_pkg::RG_CRIT_WR, cr);
			wrc(dtam_pkg::RG_CFG_WR, cf);
			cyc(2 * SLOT + 10);
			st = exp_st(lr, re, fx[1:0] == 2'd0);
			rdc(dtam_pkg::RG_LOCAL, lr);
			rdc(dtam_pkg::RG_REMOTE, re);
			rdc(dtam_pkg::RG_CFG_RD, cf);
			host_u.rd(addr, dtam_pkg::RG_STATUS, 1'b1, d, ok);
			chk8(d & st, st);
			host_u.rd(addr, 8'h00, 1'b0, d, ok);
			chk8(d, st);
			cyc(8);
			chk1(int_oe, (|(st & 8'h50) & ~cf[7]) ^ cf[1]);
			chk1(crit_oe, (st[0] & ~cf[4]) | (st[1] & ~cf[3]));
		end
		summarize();
	end
endmodule
